// file: hw/can_lp_pkg.sv
// Purpose: Shared constants and types for the CAN low-power and rx block
// Assumes: One clock domain; mailbox count fixed here
// Notes:   Interrupt vector bit positions are defined here for all users
package can_lp_pkg;

  localparam int NUM_MB  = 4;
  localparam int DATA_W  = 32;
  localparam int ID_W    = 29;
  localparam int CNT_W   = 9;
  localparam int TIMER_W = 16;
  localparam int DIV_W   = 16;
  localparam int SYNC_W  = 4;

  // Recessive bits needed before the node counts as synchronised
  localparam logic [SYNC_W-1:0] SYNC_RECESSIVE_BITS = 4'hb;
  localparam logic [SYNC_W-1:0] SYNC_LAST = SYNC_RECESSIVE_BITS - 4'h1;

  localparam logic [CNT_W-1:0] ERR_WARN_LIMIT    = 9'h060;
  localparam logic [CNT_W-1:0] ERR_PASSIVE_LIMIT = 9'h080;
  localparam logic [CNT_W-1:0] ERR_BUSOFF_LIMIT  = 9'h100;
  localparam logic [CNT_W-1:0] ERR_TX_STEP       = 9'h008;
  localparam logic [CNT_W-1:0] ERR_RX_STEP       = 9'h001;
  localparam logic [CNT_W-1:0] ERR_DEC_STEP      = 9'h001;

  localparam logic [TIMER_W-1:0] TIMER_MAX = 16'hffff;

  // Interrupt source positions
  localparam int IRQ_ERR_ACTIVE  = 0;
  localparam int IRQ_WARN        = 1;
  localparam int IRQ_ERR_PASSIVE = 2;
  localparam int IRQ_BUS_OFF     = 3;
  localparam int IRQ_SLEEP       = 4;
  localparam int IRQ_WAKE        = 5;
  localparam int IRQ_TIMER_OVF   = 6;
  localparam int IRQ_TIMESTAMP   = 7;
  localparam int IRQ_MB_BASE     = 8;
  localparam int IRQ_W           = IRQ_MB_BASE + NUM_MB;

  localparam logic [IRQ_W-1:0] INT_MASK_RESET = 12'h000;

  typedef enum logic [1:0] {
    MB_DISABLED,
    MB_RX,
    MB_RX_OVERWRITE
  } mb_mode_e;

  typedef enum logic [2:0] {
    PWR_DISABLED,
    PWR_SYNC,
    PWR_AWAKE,
    PWR_DRAIN,
    PWR_SLEEP
  } pwr_state_e;

endpackage

// file: hw/can_rx_mailbox.sv
// Purpose: One receive mailbox, plain or overwrite mode
// Assumes: Store is issued only when can_accept is high
// Notes:   Lost flag set beats status read clear
`timescale 1ns/10ps
`default_nettype none
module can_rx_mailbox
  import can_lp_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              active,
  input  wire logic              cfg_write,
  input  wire mb_mode_e          cfg_mode,
  input  wire logic [ID_W-1:0]   cfg_id,
  input  wire logic [ID_W-1:0]   cfg_mask,
  input  wire logic              transfer_command,
  input  wire logic              status_read,
  input  wire logic [ID_W-1:0]   msg_id,
  input  wire logic [DATA_W-1:0] msg_data_low,
  input  wire logic [DATA_W-1:0] msg_data_high,
  input  wire logic              store,
  input  wire logic              unclaimed,
  output logic                   can_accept,
  output logic                   mailbox_ready,
  output logic                   message_lost_flag,
  output logic [DATA_W-1:0]      mailbox_data_low,
  output logic [DATA_W-1:0]      mailbox_data_high
);

  mb_mode_e          mode_reg,  mode_next;
  logic [ID_W-1:0]   id_reg,    id_next;
  logic [ID_W-1:0]   mask_reg,  mask_next;
  logic              ready_reg, ready_next;
  logic              lost_reg,  lost_next;
  logic [DATA_W-1:0] low_reg,   low_next;
  logic [DATA_W-1:0] high_reg,  high_next;
  logic              id_match;

  assign id_match = active && (mode_reg != MB_DISABLED) &&
                    (((msg_id ^ id_reg) & mask_reg) == '0);
  // Full plain mailbox refuses so a later one can take the frame
  assign can_accept = id_match &&
                      (mode_reg == MB_RX_OVERWRITE || !ready_reg);

  always_comb begin
    mode_next  = mode_reg;
    id_next    = id_reg;
    mask_next  = mask_reg;
    ready_next = ready_reg;
    lost_next  = lost_reg;
    low_next   = low_reg;
    high_next  = high_reg;
    if (status_read) begin
      lost_next = 1'b0;
    end
    if (cfg_write) begin
      mode_next  = cfg_mode;
      id_next    = cfg_id;
      mask_next  = cfg_mask;
      ready_next = 1'b0;
      lost_next  = 1'b0;
    end else if (store) begin
      low_next   = msg_data_low;
      high_next  = msg_data_high;
      ready_next = 1'b1;
      if (ready_reg) begin
        lost_next = 1'b1;
      end
    end else begin
      if (transfer_command) begin
        ready_next = 1'b0;
      end
      if (unclaimed && id_match && ready_reg && mode_reg == MB_RX) begin
        lost_next = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg  <= MB_DISABLED;
      id_reg    <= '0;
      mask_reg  <= '0;
      ready_reg <= 1'b0;
      lost_reg  <= 1'b0;
      low_reg   <= '0;
      high_reg  <= '0;
    end else begin
      mode_reg  <= mode_next;
      id_reg    <= id_next;
      mask_reg  <= mask_next;
      ready_reg <= ready_next;
      lost_reg  <= lost_next;
      low_reg   <= low_next;
      high_reg  <= high_next;
    end
  end

  assign mailbox_ready     = ready_reg;
  assign message_lost_flag = lost_reg;
  assign mailbox_data_low  = low_reg;
  assign mailbox_data_high = high_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  ready_after_store_a: assert property (
    store && !cfg_write |=> mailbox_ready)
    else $error("mailbox not ready after store");

  plain_keeps_data_a: assert property (
    mode_reg == MB_RX && ready_reg && !cfg_write |=>
    $stable(mailbox_data_low) && $stable(mailbox_data_high))
    else $error("full plain mailbox data changed");

  overwrite_lost_a: assert property (
    store && ready_reg && !cfg_write |=>
    message_lost_flag && mailbox_data_low == $past(msg_data_low))
    else $error("overwrite did not replace data and flag loss");

endmodule // can_rx_mailbox
`default_nettype wire

// file: hw/can_lowpower_init_rx_mailbox.sv
// Purpose: CAN low-power control, bus sync, error counts, irq, rx mailboxes
// Assumes: Frame decode upstream on mclk; can_rx is the raw pin
// Notes:   Control and status are plain ports, no register bus
// Notes on behaviour
// - Low power: no frames, mailboxes inactive
// - Sleep and awake flags exclusive, zero after reset
// - Awake only after eleven recessive bits
// - Sleep request waits for pending transmissions first
// - Each flag setting clears the other
// - Sleeping disables reception, freezes error counters
// - Reception stays open while draining before sleep
// - Wake resync on eleven recessive bits, flag awake
// - Idle bus: transmit allowed eleven bits later
// - Busy bus: resync at interframe, frame dropped
// - Enable resets protocol, counters and error flags
// - Autobaud listening locks counters, no transmit
// - Enable and disable writes edit mask, reset masked
// - Error state and warning sources above 96
// - Frame edges capture timer, rollover flagged
// - Level sources self clear, timer flags on read
// - Receive mailbox ready handling with transfer command
// - Plain mailbox keeps data, flags lost message
// - Overwrite mailbox replaces data, flags lost message
// - Lowest numbered accepting mailbox takes the frame
`timescale 1ns/10ps
`default_nettype none
module can_lowpower_init_rx_mailbox
  import can_lp_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              can_rx,
  input  wire logic [DIV_W-1:0]  bit_period,
  input  wire logic              controller_enable,
  input  wire logic              low_power_request,
  input  wire logic              autobaud_listen,
  input  wire logic              tx_pending,
  input  wire logic              rec_inc,
  input  wire logic              rec_dec,
  input  wire logic              tec_inc,
  input  wire logic              tec_dec,
  input  wire logic              sof_event,
  input  wire logic              eof_event,
  input  wire logic              rx_frame_valid,
  input  wire logic [ID_W-1:0]   rx_frame_id,
  input  wire logic [DATA_W-1:0] rx_frame_data_low,
  input  wire logic [DATA_W-1:0] rx_frame_data_high,
  input  wire logic [NUM_MB-1:0] mb_cfg_write,
  input  wire mb_mode_e          mb_cfg_mode,
  input  wire logic [ID_W-1:0]   mb_cfg_id,
  input  wire logic [ID_W-1:0]   mb_cfg_mask,
  input  wire logic [NUM_MB-1:0] transfer_command,
  input  wire logic [NUM_MB-1:0] mb_status_read,
  input  wire logic              int_enable_write,
  input  wire logic              int_disable_write,
  input  wire logic [IRQ_W-1:0]  int_write_bits,
  input  wire logic              status_read,
  output logic                   low_power_flag,
  output logic                   bus_awake_flag,
  output logic                   tx_allowed,
  output logic                   rx_enabled,
  output logic                   listen_only,
  output logic                   protocol_reset,
  output logic [CNT_W-1:0]       rec_count,
  output logic [CNT_W-1:0]       tec_count,
  output logic [IRQ_W-1:0]       global_status_register,
  output logic [IRQ_W-1:0]       interrupt_mask_register,
  output logic                   irq,
  output logic [TIMER_W-1:0]     timestamp_capture,
  output logic [NUM_MB-1:0]      mailbox_ready,
  output logic [NUM_MB-1:0]      message_lost_flag,
  output logic [DATA_W-1:0]      mailbox_data_low  [NUM_MB],
  output logic [DATA_W-1:0]      mailbox_data_high [NUM_MB]
);

  // Pin synchroniser; only rx_s2_reg is read by logic
  logic rx_s1_reg;
  logic rx_s2_reg;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
    end else begin
      rx_s1_reg <= can_rx;
      rx_s2_reg <= rx_s1_reg;
    end
  end

  // Bit-time enable from a divider
  logic [DIV_W-1:0] div_reg, div_next;
  logic             bit_tick;
  assign bit_tick = (div_reg >= bit_period);
  always_comb begin
    div_next = bit_tick ? '0 : div_reg + 16'h0001;
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  // Power and synchronisation state
  pwr_state_e        state_reg,  state_next;
  logic [SYNC_W-1:0] sync_cnt_reg, sync_cnt_next;
  logic              sleep_reg,  sleep_next;
  logic              awake_reg,  awake_next;
  logic              en_d_reg;
  logic              enable_rise;
  assign enable_rise = controller_enable && !en_d_reg;

  always_comb begin
    state_next    = state_reg;
    sync_cnt_next = sync_cnt_reg;
    sleep_next    = sleep_reg;
    awake_next    = awake_reg;
    if (!controller_enable) begin
      state_next = PWR_DISABLED;
      sleep_next = 1'b0;
      awake_next = 1'b0;
    end else if (enable_rise) begin
      state_next    = PWR_SYNC;
      sync_cnt_next = '0;
    end else begin
      unique case (state_reg)
        PWR_DISABLED: state_next = PWR_SYNC;
        PWR_SYNC: begin
          if (bit_tick) begin
            if (!rx_s2_reg) begin
              sync_cnt_next = '0;
            end else if (sync_cnt_reg == SYNC_LAST) begin
              state_next = PWR_AWAKE;
              awake_next = 1'b1;
              sleep_next = 1'b0;
            end else begin
              sync_cnt_next = sync_cnt_reg + 4'h1;
            end
          end
        end
        PWR_AWAKE: begin
          if (low_power_request) begin
            state_next = PWR_DRAIN;
          end
        end
        PWR_DRAIN: begin
          if (!low_power_request) begin
            state_next = PWR_AWAKE;
          end else if (!tx_pending) begin
            state_next = PWR_SLEEP;
            sleep_next = 1'b1;
            awake_next = 1'b0;
          end
        end
        PWR_SLEEP: begin
          if (!low_power_request) begin
            state_next    = PWR_SYNC;
            sync_cnt_next = '0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg    <= PWR_DISABLED;
      sync_cnt_reg <= '0;
      sleep_reg    <= 1'b0;
      awake_reg    <= 1'b0;
      en_d_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      sync_cnt_reg <= sync_cnt_next;
      sleep_reg    <= sleep_next;
      awake_reg    <= awake_next;
      en_d_reg     <= controller_enable;
    end
  end

  assign low_power_flag = sleep_reg;
  assign bus_awake_flag = awake_reg;
  assign protocol_reset = enable_rise;
  // Draining still hears frames that beat our last transmission
  assign rx_enabled = (state_reg == PWR_AWAKE || state_reg == PWR_DRAIN) &&
                      !sleep_reg;
  assign tx_allowed = rx_enabled && !autobaud_listen;
  assign listen_only = autobaud_listen;

  // Error counters
  logic [CNT_W-1:0] rec_reg, rec_next;
  logic [CNT_W-1:0] tec_reg, tec_next;
  logic             cnt_frozen;
  assign cnt_frozen = sleep_reg || autobaud_listen ||
                      state_reg == PWR_DISABLED;

  always_comb begin
    rec_next = rec_reg;
    tec_next = tec_reg;
    if (enable_rise) begin
      rec_next = '0;
      tec_next = '0;
    end else if (!cnt_frozen) begin
      if (rec_inc && rec_reg < ERR_BUSOFF_LIMIT) begin
        rec_next = rec_reg + ERR_RX_STEP;
      end else if (rec_dec && rec_reg != '0) begin
        rec_next = rec_reg - ERR_DEC_STEP;
      end
      // Saturate near bus-off so the counter cannot wrap
      if (tec_inc && tec_reg < ERR_BUSOFF_LIMIT) begin
        tec_next = tec_reg + ERR_TX_STEP;
      end else if (tec_dec && tec_reg != '0) begin
        tec_next = tec_reg - ERR_DEC_STEP;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rec_reg <= '0;
      tec_reg <= '0;
    end else begin
      rec_reg <= rec_next;
      tec_reg <= tec_next;
    end
  end

  assign rec_count = rec_reg;
  assign tec_count = tec_reg;

  logic bus_off;
  logic err_passive;
  logic err_active;
  logic err_warn;
  assign bus_off     = tec_reg >= ERR_BUSOFF_LIMIT;
  assign err_passive = !bus_off && (tec_reg >= ERR_PASSIVE_LIMIT ||
                                    rec_reg >= ERR_PASSIVE_LIMIT);
  assign err_active  = !bus_off && !err_passive;
  assign err_warn    = err_active && (tec_reg > ERR_WARN_LIMIT ||
                                      rec_reg > ERR_WARN_LIMIT);

  // Timer, timestamp and the two read-cleared sources
  logic [TIMER_W-1:0] timer_reg, timer_next;
  logic [TIMER_W-1:0] stamp_reg, stamp_next;
  logic               ovf_reg,   ovf_next;
  logic               tsf_reg,   tsf_next;
  logic               stamp_set;
  logic               ovf_set;
  assign stamp_set = sof_event || eof_event;
  assign ovf_set   = bit_tick && timer_reg == TIMER_MAX;

  always_comb begin
    timer_next = bit_tick ? timer_reg + 16'h0001 : timer_reg;
    stamp_next = stamp_set ? timer_reg : stamp_reg;
    // Set beats the read clear so no edge is lost
    ovf_next = ovf_set || (ovf_reg && !status_read);
    tsf_next = stamp_set || (tsf_reg && !status_read);
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_reg <= '0;
      stamp_reg <= '0;
      ovf_reg   <= 1'b0;
      tsf_reg   <= 1'b0;
    end else begin
      timer_reg <= timer_next;
      stamp_reg <= stamp_next;
      ovf_reg   <= ovf_next;
      tsf_reg   <= tsf_next;
    end
  end

  assign timestamp_capture = stamp_reg;

  // Receive mailboxes
  logic [NUM_MB-1:0] mb_accept;
  logic [NUM_MB-1:0] mb_store;
  logic              claimed;
  logic              frame_in;
  assign frame_in = rx_frame_valid && rx_enabled;

  always_comb begin
    claimed  = 1'b0;
    mb_store = '0;
    for (int i = 0; i < NUM_MB; i++) begin
      mb_store[i] = frame_in && mb_accept[i] && !claimed;
      claimed     = claimed || mb_accept[i];
    end
  end

  for (genvar g = 0; g < NUM_MB; g++) begin : g_mb
    can_rx_mailbox u_mb (
      .mclk              (mclk),
      .sys_rst           (sys_rst),
      .active            (rx_enabled),
      .cfg_write         (mb_cfg_write[g]),
      .cfg_mode          (mb_cfg_mode),
      .cfg_id            (mb_cfg_id),
      .cfg_mask          (mb_cfg_mask),
      .transfer_command  (transfer_command[g]),
      .status_read       (mb_status_read[g]),
      .msg_id            (rx_frame_id),
      .msg_data_low      (rx_frame_data_low),
      .msg_data_high     (rx_frame_data_high),
      .store             (mb_store[g]),
      .unclaimed         (frame_in && !claimed),
      .can_accept        (mb_accept[g]),
      .mailbox_ready     (mailbox_ready[g]),
      .message_lost_flag (message_lost_flag[g]),
      .mailbox_data_low  (mailbox_data_low[g]),
      .mailbox_data_high (mailbox_data_high[g])
    );
  end

  // Interrupt status and mask; a set bit in the mask means enabled
  logic [IRQ_W-1:0] mask_reg, mask_next;
  always_comb begin
    global_status_register                  = '0;
    global_status_register[IRQ_ERR_ACTIVE]  = err_active;
    global_status_register[IRQ_WARN]        = err_warn;
    global_status_register[IRQ_ERR_PASSIVE] = err_passive;
    global_status_register[IRQ_BUS_OFF]     = bus_off;
    global_status_register[IRQ_SLEEP]       = sleep_reg;
    global_status_register[IRQ_WAKE]        = awake_reg;
    global_status_register[IRQ_TIMER_OVF]   = ovf_reg;
    global_status_register[IRQ_TIMESTAMP]   = tsf_reg;
    global_status_register[IRQ_MB_BASE +: NUM_MB] = mailbox_ready;
  end

  always_comb begin
    mask_next = mask_reg;
    if (int_enable_write) begin
      mask_next = mask_next | int_write_bits;
    end
    if (int_disable_write) begin
      mask_next = mask_next & ~int_write_bits;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_reg <= INT_MASK_RESET;
    end else begin
      mask_reg <= mask_next;
    end
  end

  assign interrupt_mask_register = mask_reg;
  assign irq = |(global_status_register & mask_reg);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence drain_done_s;
    state_reg == PWR_DRAIN && controller_enable && !enable_rise &&
    low_power_request && !tx_pending;
  endsequence

  sequence asleep_s;
    low_power_flag && !bus_awake_flag && !rx_enabled;
  endsequence

  flags_exclusive_a: assert property (
    !(low_power_flag && bus_awake_flag))
    else $error("sleep and awake flags both set");

  sleep_entry_a: assert property (
    drain_done_s |=> asleep_s)
    else $error("sleep not entered after drain");

  sleep_waits_tx_a: assert property (
    $rose(low_power_flag) |-> $past(!tx_pending))
    else $error("sleep entered with transmission pending");

  no_rx_asleep_a: assert property (
    low_power_flag |-> mb_store == '0 && !tx_allowed)
    else $error("frame activity while asleep");

  counters_frozen_a: assert property (
    cnt_frozen && !enable_rise |=> $stable(rec_count) && $stable(tec_count))
    else $error("error counter moved while frozen");

  enable_clears_a: assert property (
    enable_rise |=> rec_count == '0 && tec_count == '0 &&
    state_reg == PWR_SYNC)
    else $error("enable did not reset counters");

  wake_after_run_a: assert property (
    $rose(bus_awake_flag) |-> $past(sync_cnt_reg) == SYNC_LAST &&
    $past(rx_s2_reg) && $past(bit_tick))
    else $error("awake without eleven recessive bits");

  mask_disable_a: assert property (
    int_disable_write |=> (interrupt_mask_register &
    $past(int_write_bits)) == '0)
    else $error("disable write left source enabled");

  stamp_clear_a: assert property (
    status_read && !stamp_set |=>
    !global_status_register[IRQ_TIMESTAMP])
    else $error("timestamp flag survived status read");

  lowest_mailbox_a: assert property (
    $onehot0(mb_store) && (!frame_in || mb_accept == '0 ||
    ($onehot(mb_store) && ((mb_store - 4'h1) & mb_accept) == '0)))
    else $error("frame not taken by lowest accepting mailbox");

endmodule // can_lowpower_init_rx_mailbox
`default_nettype wire

// file: bench/can_bus_model.sv
// Purpose: CAN bus partner seen through the transceiver pin
// Assumes: Bit time is bit_period+1 mclk cycles
// Notes:   Busy traffic never shows eleven recessive bits in a row
`timescale 1ns/10ps
`default_nettype none
module can_bus_model
  import can_lp_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             busy,
  input  wire logic [DIV_W-1:0] bit_period,
  output logic                  can_rx
);
  logic [DIV_W-1:0] cnt_reg = 16'h0000;
  logic             lvl_reg = 1'b0;

  always_ff @(posedge mclk) begin
    if (cnt_reg >= bit_period) begin
      cnt_reg <= 16'h0000;
      lvl_reg <= ~lvl_reg;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
  // Idle bus floats recessive through the pull-up
  assign can_rx = busy ? lvl_reg : 1'b1;
endmodule // can_bus_model
`default_nettype wire

// file: bench/test_can_lowpower_init_rx_mailbox.sv
// Purpose: Self-checking bench for the CAN low-power and rx block
// Assumes: Bit time of four mclk cycles, all id bits compared
// Notes:   Frames and counter events come as upstream pulses
`timescale 1ns/10ps
`default_nettype none
module test_can_lowpower_init_rx_mailbox
  import can_lp_pkg::*;
;
  `define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
  `define WAITF(c) begin k = 0; while (!(c) && k < 2000) begin look(); \
    k++; end if (!(c)) begin err_total++; test_done(); end end

  logic mclk, sys_rst, can_rx, busy, controller_enable, low_power_request;
  logic autobaud_listen, tx_pending, rec_inc, rec_dec, tec_inc, tec_dec;
  logic sof_event, eof_event, rx_frame_valid, status_read;
  logic int_enable_write, int_disable_write;
  logic low_power_flag, bus_awake_flag, tx_allowed, rx_enabled;
  logic listen_only, protocol_reset, irq;
  logic [DIV_W-1:0]   bit_period;
  logic [ID_W-1:0]    rx_frame_id, mb_cfg_id, mb_cfg_mask;
  logic [DATA_W-1:0]  rx_frame_data_low, rx_frame_data_high;
  logic [NUM_MB-1:0]  mb_cfg_write, transfer_command, mb_status_read;
  logic [NUM_MB-1:0]  mailbox_ready, message_lost_flag;
  mb_mode_e           mb_cfg_mode;
  logic [IRQ_W-1:0]   int_write_bits, global_status_register;
  logic [IRQ_W-1:0]   interrupt_mask_register;
  logic [CNT_W-1:0]   rec_count, tec_count;
  logic [TIMER_W-1:0] timestamp_capture;
  logic [DATA_W-1:0]  mailbox_data_low [NUM_MB];
  logic [DATA_W-1:0]  mailbox_data_high [NUM_MB];
  int                 err_total, n_tests, k;

  can_bus_model bus (.mclk, .busy, .bit_period, .can_rx);

  can_lowpower_init_rx_mailbox dut (
    .mclk, .sys_rst, .can_rx, .bit_period, .controller_enable,
    .low_power_request, .autobaud_listen, .tx_pending, .rec_inc, .rec_dec,
    .tec_inc, .tec_dec, .sof_event, .eof_event, .rx_frame_valid,
    .rx_frame_id, .rx_frame_data_low, .rx_frame_data_high, .mb_cfg_write,
    .mb_cfg_mode, .mb_cfg_id, .mb_cfg_mask, .transfer_command,
    .mb_status_read, .int_enable_write, .int_disable_write,
    .int_write_bits, .status_read, .low_power_flag, .bus_awake_flag,
    .tx_allowed, .rx_enabled, .listen_only, .protocol_reset, .rec_count,
    .tec_count, .global_status_register, .interrupt_mask_register, .irq,
    .timestamp_capture, .mailbox_ready, .message_lost_flag,
    .mailbox_data_low, .mailbox_data_high);

  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk);
  endtask

  task automatic look;
    @(negedge mclk);
  endtask

  task automatic test_done;
    $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic frame(input logic [ID_W-1:0] id, input logic [31:0] d);
    tick();
    rx_frame_valid <= 1'b1;
    rx_frame_id <= id;
    rx_frame_data_low <= d;
    rx_frame_data_high <= ~d;
    tick();
    rx_frame_valid <= 1'b0;
    look();
  endtask

  task automatic cfg(input int i, input mb_mode_e m, input logic [28:0] id);
    tick();
    mb_cfg_write <= NUM_MB'(1 << i);
    mb_cfg_mode <= m;
    mb_cfg_id <= id;
    tick();
    mb_cfg_write <= 4'h0;
  endtask

  task automatic pulse_tc(input logic [3:0] v);
    tick();
    transfer_command <= v;
    tick();
    transfer_command <= 4'h0;
  endtask

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial begin
    {busy, controller_enable, low_power_request, autobaud_listen} = 4'h0;
    {tx_pending, rec_inc, rec_dec, tec_inc, tec_dec, sof_event} = 6'h00;
    {eof_event, rx_frame_valid, status_read, int_enable_write} = 4'h0;
    {int_disable_write, mb_cfg_write, transfer_command} = 9'h000;
    {rx_frame_id, rx_frame_data_low, rx_frame_data_high, mb_cfg_id} = '0;
    {mb_status_read, int_write_bits} = 16'h0000;
    mb_cfg_mode = MB_DISABLED;
    mb_cfg_mask = '1;
    err_total = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    bit_period = 16'h0003;
    tick(6);
    sys_rst <= 1'b0;
    look();
    `CHK({low_power_flag, bus_awake_flag}, 2'b00)
    `CHK(interrupt_mask_register, INT_MASK_RESET)
    tick();
    controller_enable <= 1'b1;
    tick(30);
    look();
    `CHK(bus_awake_flag, 1'b0)
    `WAITF(bus_awake_flag)
    look();
    `CHK(low_power_flag, 1'b0)
    tick();
    int_enable_write <= 1'b1;
    int_write_bits <= 12'hfff;
    tick();
    int_enable_write <= 1'b0;
    int_disable_write <= 1'b1;
    int_write_bits <= 12'hfdf;
    tick();
    int_disable_write <= 1'b0;
    look();
    `CHK(interrupt_mask_register, 12'h020)
    `CHK(irq, 1'b1)
    tick();
    tec_inc <= 1'b1;
    tick(13);
    tec_inc <= 1'b0;
    autobaud_listen <= 1'b1;
    rec_inc <= 1'b1;
    tick();
    rec_inc <= 1'b0;
    look();
    `CHK(tec_count, 9'h068)
    `CHK(global_status_register[IRQ_WARN], 1'b1)
    `CHK(rec_count, 9'h000)
    `CHK(listen_only, 1'b1)
    `CHK(global_status_register[IRQ_ERR_ACTIVE], 1'b1)
    tick();
    autobaud_listen <= 1'b0;
    controller_enable <= 1'b0;
    tick();
    controller_enable <= 1'b1;
    look();
    `CHK(protocol_reset, 1'b1)
    tick();
    look();
    `CHK(tec_count, 9'h000)
    `WAITF(bus_awake_flag)
    cfg(0, MB_RX, 29'h0000_0123);
    cfg(1, MB_RX_OVERWRITE, 29'h0000_0123);
    cfg(2, MB_RX, 29'h0000_0456);
    frame(29'h0000_0123, 32'h1111_1111);
    `CHK(mailbox_ready, 4'h1)
    frame(29'h0000_0123, 32'h2222_2222);
    `CHK(mailbox_data_low[1], 32'h2222_2222)
    `CHK(mailbox_data_low[0], 32'h1111_1111)
    frame(29'h0000_0123, 32'h3333_3333);
    `CHK(mailbox_data_high[1], 32'hcccc_cccc)
    `CHK(message_lost_flag, 4'h2)
    tick();
    mb_status_read <= 4'h2;
    tick();
    mb_status_read <= 4'h0;
    look();
    `CHK(message_lost_flag, 4'h0)
    frame(29'h0000_0456, 32'h4444_4444);
    frame(29'h0000_0456, 32'h5555_5555);
    `CHK(mailbox_data_low[2], 32'h4444_4444)
    `CHK(message_lost_flag, 4'h4)
    pulse_tc(4'h1);
    look();
    `CHK(mailbox_ready, 4'h6)
    tick();
    sof_event <= 1'b1;
    tick();
    sof_event <= 1'b0;
    look();
    `CHK(global_status_register[IRQ_TIMESTAMP], 1'b1)
    `CHK(timestamp_capture == 16'h0000, 1'b0)
    tick();
    status_read <= 1'b1;
    eof_event <= 1'b1;
    tick();
    eof_event <= 1'b0;
    look();
    `CHK(global_status_register[IRQ_TIMESTAMP], 1'b1)
    tick();
    status_read <= 1'b0;
    look();
    `CHK(global_status_register[IRQ_TIMESTAMP], 1'b0)
    tick();
    tx_pending <= 1'b1;
    low_power_request <= 1'b1;
    tick(10);
    look();
    `CHK(low_power_flag, 1'b0)
    frame(29'h0000_0123, 32'h6666_6666);
    `CHK(mailbox_ready[0], 1'b1)
    tick();
    tx_pending <= 1'b0;
    tick(2);
    look();
    `CHK({low_power_flag, bus_awake_flag}, 2'b10)
    `CHK(rx_enabled, 1'b0)
    pulse_tc(4'h1);
    rec_inc <= 1'b1;
    tick();
    rec_inc <= 1'b0;
    frame(29'h0000_0123, 32'h7777_7777);
    `CHK(mailbox_ready[0], 1'b0)
    `CHK(rec_count, 9'h000)
    tick();
    busy <= 1'b1;
    low_power_request <= 1'b0;
    tick(100);
    frame(29'h0000_0123, 32'h8888_8888);
    `CHK(mailbox_ready[0], 1'b0)
    `CHK({low_power_flag, bus_awake_flag}, 2'b10)
    tick();
    busy <= 1'b0;
    `WAITF(bus_awake_flag)
    look();
    `CHK(low_power_flag, 1'b0)
    `CHK(tx_allowed, 1'b1)
    test_done();
  end
endmodule // test_can_lowpower_init_rx_mailbox
`default_nettype wire
